// ==== logic/scr_regmap.sv ====
// Register map core of the programmable sensor: decodes telegrams,
// holds volatile copies, runs the store pair and the silence state.
// Assumes the supply front end delivers demodulated bits on this clock
// and that reload_i marks a supply cycle without wiping the cells.
`timescale 1ns/1ps
`default_nettype none

module scr_regmap
    import scr_pkg::*;
#(
    parameter int BIT_CYCLES = OUT_BIT_CYCLES
) (
    input  wire logic         core_clk_i,
    input  wire logic         rst_i,
    input  wire logic         reload_i,
    input  wire logic         rx_sync_i,
    input  wire logic         rx_bit_valid_i,
    input  wire logic         rx_bit_i,
    input  wire logic         activate_pin_i,
    input  wire logic [13:0]  conv_value_i,
    output logic              out_bit_o,
    output logic              out_bit_stb_o,
    output logic              out_forced_low_o,
    output logic              lock_active_o,
    output logic [7:0]        low_clamp_o,
    output logic [8:0]        high_clamp_o,
    output logic [10:0]       quiescent_o,
    output logic [13:0]       gain_o,
    output logic [7:0]        config_o,
    output logic [9:0]        temp_coef_o
);

    scr_state_type state_q;              // Loading or running
    logic [13:0]   ram_q [NUM_REGS];     // Volatile copies
    logic [3:0]    ld_idx_q;             // Cell being fetched
    logic [3:0]    ld_prev_q;            // Cell whose data is arriving
    logic          ld_cap_q;             // Fetched data is valid
    logic [2:0]    act_sync_q;           // Activate pin synchroniser
    logic          act_level_q;          // Agreed pin level

    // Framer outputs and the cell read port
    logic        frm_valid;
    logic [2:0]  frm_cmd;
    logic [3:0]  frm_addr;
    logic [13:0] frm_data;
    logic        frm_ok;
    logic        tx_busy;
    logic [13:0] mem_rd;

    // Pin wake-up edge counts once stages two and three agree
    wire act_agree = act_sync_q[1] == act_sync_q[2];
    wire act_edge  = act_agree && act_sync_q[2] && !act_level_q;

    // Command qualification; a silenced sensor accepts nothing
    wire go       = state_q == ST_RUN && frm_valid && frm_ok
                 && !out_forced_low_o && !tx_busy;
    wire is_rd    = frm_cmd == CMD_READ;
    wire is_wr    = frm_cmd == CMD_WRITE;
    wire is_store = frm_cmd == CMD_ERASE || frm_cmd == CMD_PROG;
    wire wr_ok    = go && is_wr && WR_MASK[frm_addr]
                 && !lock_active_o;
    wire silence  = go && is_wr && frm_addr == ADDR_SILENCE
                 && frm_data[11:0] == SILENCE_VALUE;
    wire rd_ok    = go && is_rd && RD_MASK[frm_addr];
    wire st_ok    = go && is_store && frm_addr == ADDR_STORE
                 && !lock_active_o;
    wire mem_erase = st_ok && frm_cmd == CMD_ERASE;
    wire mem_prog  = st_ok && frm_cmd == CMD_PROG;
    wire lock_wr   = wr_ok && frm_addr == ADDR_LOCK;

    // Width and alignment of the addressed register
    wire [4:0]  rw_width = 5'(reg_width(frm_addr));
    wire [13:0] wr_mask  = 14'((15'h1 << rw_width) - 15'h1);
    wire [13:0] wr_val   = frm_data & wr_mask;

    // Readback bit order turned round before the MSB-first shifter
    logic [13:0] conv_rev;
    for (genvar b = 0; b < DATA_W; b++) begin : g_rev
        assign conv_rev[b] = conv_value_i[DATA_W-1-b];
    end

    wire [13:0] rd_src  = frm_addr == ADDR_READBACK ? conv_rev
                                                    : ram_q[frm_addr];
    wire [13:0] rd_data = 14'(rd_src << (5'(DATA_W) - rw_width));
    wire        rd_par  = ~^(~rd_data);
    wire        tx_load = wr_ok || rd_ok || st_ok;
    wire [15:0] tx_word = rd_ok ? {1'b0, rd_data, rd_par} : 16'h0;

    // Store masks: lock never, general-purpose only when enabled
    wire        gp_en      = ram_q[ADDR_CONFIG][CFG_GP_EN_POS];
    wire [15:0] store_mask = STORE_BASE
                           | (gp_en ? STORE_GP : 16'h0);

    // Volatile copies packed for the parallel program strobe
    logic [NUM_REGS*DATA_W-1:0] prog_flat;
    for (genvar r = 0; r < NUM_REGS; r++) begin : g_pack
        assign prog_flat[r*DATA_W +: DATA_W] = ram_q[r];
    end

    // Telegram framer and reply pacer
    scr_frame #(
        .BIT_CYCLES (BIT_CYCLES)
    ) u_frame (
        .core_clk_i     (core_clk_i),
        .rst_i          (rst_i),
        .rx_sync_i      (rx_sync_i),
        .rx_bit_valid_i (rx_bit_valid_i),
        .rx_bit_i       (rx_bit_i),
        .frm_valid_o    (frm_valid),
        .frm_cmd_o      (frm_cmd),
        .frm_addr_o     (frm_addr),
        .frm_data_o     (frm_data),
        .frm_ok_o       (frm_ok),
        .tx_load_i      (tx_load),
        .tx_long_i      (rd_ok),
        .tx_word_i      (tx_word),
        .tx_busy_o      (tx_busy),
        .tx_bit_o       (out_bit_o),
        .tx_stb_o       (out_bit_stb_o)
    );

    // Nonvolatile cells; lock is written straight through
    scr_nvmem #(
        .WIDTH (DATA_W),
        .DEPTH (NUM_REGS)
    ) u_nvmem (
        .core_clk_i  (core_clk_i),
        .rst_i       (rst_i),
        .erase_i     (mem_erase),
        .prog_i      (mem_prog),
        .mask_i      (store_mask),
        .prog_data_i (prog_flat),
        .wr_en_i     (lock_wr),
        .wr_addr_i   (ADDR_LOCK),
        .wr_data_i   (wr_val),
        .rd_addr_i   (ld_idx_q),
        .rd_data_o   (mem_rd)
    );

    // Sequencer: fetch every cell after power-up, then run
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q   <= ST_LOAD;
            ld_idx_q  <= '0;
            ld_prev_q <= '0;
            ld_cap_q  <= 1'b0;
        end else if (reload_i) begin
            state_q   <= ST_LOAD;            // Supply cycle
            ld_idx_q  <= '0;
            ld_cap_q  <= 1'b0;
        end else if (state_q == ST_LOAD) begin
            ld_idx_q  <= ld_idx_q + 4'h1;
            ld_prev_q <= ld_idx_q;
            ld_cap_q  <= 1'b1;
            if (ld_cap_q && ld_prev_q == 4'hf) begin
                state_q <= ST_RUN;
            end
        end
    end

    // Volatile copies: filled from cells, then by accepted writes
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                ram_q[i] <= REG_RST;
            end
        end else if (state_q == ST_LOAD && ld_cap_q) begin
            ram_q[ld_prev_q] <= mem_rd;
        end else if (wr_ok) begin
            ram_q[frm_addr] <= wr_val;
        end
    end

    // Lock is sampled only while loading, so a new lock waits for power-up
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            lock_active_o <= 1'b0;
        end else if (state_q == ST_LOAD && ld_cap_q
                     && ld_prev_q == ADDR_LOCK) begin
            lock_active_o <= |mem_rd[1:0];
        end
    end

    // Activate pin: three flops, then a filtered level
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            act_sync_q  <= '0;
            act_level_q <= 1'b0;
        end else begin
            act_sync_q <= {act_sync_q[1:0], activate_pin_i};
            if (act_agree) begin
                act_level_q <= act_sync_q[2];
            end
        end
    end

    // Silence state; wake wins over a same-cycle silence request
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            out_forced_low_o <= 1'b0;
        end else if (act_edge || reload_i) begin
            out_forced_low_o <= 1'b0;
        end else if (silence) begin
            out_forced_low_o <= 1'b1;
        end
    end

    // Analog settings straight from the volatile copies
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            low_clamp_o  <= '0;
            high_clamp_o <= '0;
            quiescent_o  <= '0;
            gain_o       <= '0;
            config_o     <= '0;
            temp_coef_o  <= '0;
        end else begin
            low_clamp_o  <= ram_q[ADDR_LOW_CLAMP][7:0];
            high_clamp_o <= ram_q[ADDR_HIGH_CLAMP][8:0];
            quiescent_o  <= ram_q[ADDR_QUIESCENT][10:0];
            gain_o       <= ram_q[ADDR_GAIN];
            config_o     <= ram_q[ADDR_CONFIG][7:0];
            temp_coef_o  <= ram_q[ADDR_TEMP_COEF][9:0];
        end
    end

    // Checks
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    sequence s_reload;
        reload_i ##1 state_q == ST_LOAD;
    endsequence

    a_silence_output_low: assert property (
        silence && !act_edge && !reload_i |=> out_forced_low_o[*3])
        else $error("silence write did not force output low");
    a_wake_on_pin: assert property (
        act_edge |=> !out_forced_low_o)
        else $error("activate pulse did not wake sensor");
    a_store_addr_zero: assert property (
        (mem_erase || mem_prog) |-> frm_addr == 4'h0 && frm_cmd[2])
        else $error("store accepted at nonzero address");
    a_gp_cells_kept: assert property (
        mem_prog && !config_o[0] && $stable(config_o)
        |-> store_mask[8] == 1'b0 && store_mask[12] == 1'b0)
        else $error("general-purpose cells stored without enable");
    a_lock_excluded: assert property (
        st_ok |-> store_mask[6] == 1'b0 && store_mask[5:1] == 5'h1f)
        else $error("store mask wrong");
    a_read_aligned: assert property (
        rd_ok && frm_addr == ADDR_LOW_CLAMP
        |-> tx_word[6:1] == 6'h0 && tx_word[14:7] == ram_q[1][7:0])
        else $error("read data not high-aligned");
    a_readback_rev: assert property (
        rd_ok && frm_addr == ADDR_READBACK
        |-> tx_word[1] == conv_value_i[13] && tx_word[14] == conv_value_i[0])
        else $error("readback bits not reversed");
    a_readback_ro: assert property (
        go && is_wr && frm_addr == ADDR_READBACK
        |=> $stable(ram_q[ADDR_READBACK]) && !tx_busy)
        else $error("write to readback register accepted");
    a_reply_parity: assert property (
        rd_ok |-> tx_word[0] == ~^(~tx_word[14:1]) ##1 tx_busy)
        else $error("reply parity wrong or reply not started");
    a_lock_at_load: assert property (
        state_q == ST_RUN && $past(state_q) == ST_RUN
        |-> $stable(lock_active_o))
        else $error("lock changed outside power-up");
    a_reload_done: assert property (
        s_reload |-> ##[16:20] state_q == ST_RUN)
        else $error("power-up fetch did not finish");

endmodule : scr_regmap

`default_nettype wire

// ==== logic/scr_pkg.sv ====
// Shared constants for the sensor configuration register map.
// Assumes a single 40 MHz core clock; telegram bits arrive already
// demodulated by the supply-line front end on the same clock.
`default_nettype none

package scr_pkg;

    // Field widths of a telegram
    localparam int DATA_W   = 14;
    localparam int ADDR_W   = 4;
    localparam int CMD_W    = 3;
    localparam int HDR_BITS = 9;      // Command, its parity, address, parity
    localparam int WR_BITS  = 24;     // Header plus data and data parity
    localparam int REPLY_W  = 16;     // Ack, data word, data parity
    localparam int NUM_REGS = 16;

    // Command codes
    localparam logic [2:0] CMD_READ  = 3'h2;
    localparam logic [2:0] CMD_WRITE = 3'h3;
    localparam logic [2:0] CMD_PROG  = 3'h4;
    localparam logic [2:0] CMD_ERASE = 3'h5;

    // Register addresses
    localparam logic [3:0] ADDR_STORE      = 4'h0;
    localparam logic [3:0] ADDR_LOW_CLAMP  = 4'h1;
    localparam logic [3:0] ADDR_HIGH_CLAMP = 4'h2;
    localparam logic [3:0] ADDR_QUIESCENT  = 4'h3;
    localparam logic [3:0] ADDR_GAIN       = 4'h4;
    localparam logic [3:0] ADDR_CONFIG     = 4'h5;
    localparam logic [3:0] ADDR_LOCK       = 4'h6;
    localparam logic [3:0] ADDR_GP_GROUP   = 4'h8;
    localparam logic [3:0] ADDR_READBACK   = 4'h9;
    localparam logic [3:0] ADDR_TEMP_COEF  = 4'hb;
    localparam logic [3:0] ADDR_GP_ZERO    = 4'hc;
    localparam logic [3:0] ADDR_SILENCE    = 4'hf;

    // Value that silences the sensor
    localparam logic [11:0] SILENCE_VALUE = 12'h80f;

    // Address masks: writable, readable, stored by the store pair
    localparam logic [15:0] WR_MASK    = 16'h197e;
    localparam logic [15:0] RD_MASK    = 16'h1b7e;
    localparam logic [15:0] STORE_BASE = 16'h083e;
    localparam logic [15:0] STORE_GP   = 16'h1100;

    // Operating configuration fields (bit positions)
    localparam int CFG_OUT_MODE_POS = 5;
    localparam int CFG_RATE_POS     = 4;
    localparam int CFG_FILTER_POS   = 3;
    localparam int CFG_RANGE_POS    = 1;
    localparam int CFG_GP_EN_POS    = 0;

    // Temperature coefficient fields (bit positions)
    localparam int TC_GROUP_POS  = 8;
    localparam int TC_LINEAR_POS = 3;
    localparam int TC_QUAD_POS   = 0;

    // Values after reset
    localparam logic [13:0] REG_RST = 14'h0;

    // Output bit timing
    localparam int CLK_HZ          = 40_000_000;
    localparam int OUT_BIT_TIME_US = 3000;
    localparam int OUT_BIT_CYCLES  = (CLK_HZ / 1_000_000) * OUT_BIT_TIME_US;

    // Core sequencer
    typedef enum logic {
        ST_LOAD = 1'b0,
        ST_RUN  = 1'b1
    } scr_state_type;

    // Number of valid bits of each register
    function automatic int reg_width(input logic [3:0] a);
        unique case (a)
            ADDR_LOW_CLAMP:  reg_width = 8;
            ADDR_HIGH_CLAMP: reg_width = 9;
            ADDR_QUIESCENT:  reg_width = 11;
            ADDR_GAIN:       reg_width = 14;
            ADDR_CONFIG:     reg_width = 8;
            ADDR_LOCK:       reg_width = 2;
            ADDR_GP_GROUP:   reg_width = 13;
            ADDR_READBACK:   reg_width = 14;
            ADDR_TEMP_COEF:  reg_width = 10;
            ADDR_GP_ZERO:    reg_width = 13;
            ADDR_SILENCE:    reg_width = 12;
            default:         reg_width = 14;
        endcase
    endfunction : reg_width

endpackage : scr_pkg

`default_nettype wire

// ==== logic/scr_nvmem.sv ====
// Nonvolatile cell array of the register map.
// Assumes erase and program come as single-cycle strobes from the core.
`timescale 1ns/1ps
`default_nettype none

module scr_nvmem
    import scr_pkg::*;
#(
    parameter int WIDTH = 14,
    parameter int DEPTH = 16
) (
    input  wire logic                   core_clk_i,
    input  wire logic                   rst_i,
    input  wire logic                   erase_i,
    input  wire logic                   prog_i,
    input  wire logic [DEPTH-1:0]       mask_i,
    input  wire logic [WIDTH*DEPTH-1:0] prog_data_i,
    input  wire logic                   wr_en_i,
    input  wire logic [3:0]             wr_addr_i,
    input  wire logic [WIDTH-1:0]       wr_data_i,
    input  wire logic [3:0]             rd_addr_i,
    output logic      [WIDTH-1:0]       rd_data_o
);

    logic [WIDTH-1:0] cell_q [DEPTH];   // Cell contents

    // One process per cell; erase and program hit every masked cell at once
    for (genvar i = 0; i < DEPTH; i++) begin : g_cell
        always_ff @(posedge core_clk_i or posedge rst_i) begin
            if (rst_i) begin
                cell_q[i] <= REG_RST;   // Blank array on first power
            end else if (erase_i && mask_i[i]) begin
                cell_q[i] <= '0;
            end else if (prog_i && mask_i[i]) begin
                cell_q[i] <= prog_data_i[i*WIDTH +: WIDTH];
            end else if (wr_en_i && wr_addr_i == 4'(i)) begin
                cell_q[i] <= wr_data_i;  // Direct path for the lock cell
            end
        end
    end

    // Registered read port
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_data_o <= '0;
        end else begin
            rd_data_o <= cell_q[rd_addr_i];
        end
    end

endmodule : scr_nvmem

`default_nettype wire

// ==== logic/scr_frame.sv ====
// Telegram framer: collects demodulated bits, paces reply bits out.
// Assumes bits arrive as same-clock strobes after a sync pulse.
`timescale 1ns/1ps
`default_nettype none

module scr_frame
    import scr_pkg::*;
#(
    parameter int BIT_CYCLES = OUT_BIT_CYCLES
) (
    input  wire logic         core_clk_i,
    input  wire logic         rst_i,
    input  wire logic         rx_sync_i,
    input  wire logic         rx_bit_valid_i,
    input  wire logic         rx_bit_i,
    output logic              frm_valid_o,
    output logic [2:0]        frm_cmd_o,
    output logic [3:0]        frm_addr_o,
    output logic [13:0]       frm_data_o,
    output logic              frm_ok_o,
    input  wire logic         tx_load_i,
    input  wire logic         tx_long_i,
    input  wire logic [15:0]  tx_word_i,
    output logic              tx_busy_o,
    output logic              tx_bit_o,
    output logic              tx_stb_o
);

    logic [23:0] sh_q;          // Received bits, newest at bit 0
    logic [4:0]  cnt_q;         // Bits received since sync
    logic        act_q;         // Inside a telegram
    logic [15:0] tx_sh_q;       // Reply bits, MSB first
    logic [4:0]  tx_cnt_q;      // Reply bits left
    logic [31:0] div_q;         // Output bit-time divider

    wire  [23:0] nsh      = {sh_q[22:0], rx_bit_i};
    wire  [4:0]  ncnt     = cnt_q + 5'h1;
    wire         take     = act_q && rx_bit_valid_i;
    wire         end_hdr  = ncnt == 5'(HDR_BITS) && nsh[8:6] != CMD_WRITE;
    wire         end_long = ncnt == 5'(WR_BITS);
    wire  [8:0]  hdr      = end_long ? nsh[23:15] : nsh[8:0];
    wire         hdr_ok   = (hdr[5] == ^(~hdr[8:6]))
                         && (hdr[0] == ^(~hdr[4:1]));
    wire         dat_ok   = nsh[0] == ~^(~nsh[14:1]);
    wire         tick     = div_q == 32'(BIT_CYCLES - 1);

    // Receive shifter; a new sync restarts the frame
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sh_q  <= '0;
            cnt_q <= '0;
            act_q <= 1'b0;
        end else if (rx_sync_i) begin
            cnt_q <= '0;
            act_q <= 1'b1;
        end else if (take) begin
            sh_q  <= nsh;
            cnt_q <= ncnt;
            act_q <= !(end_hdr || end_long);
        end
    end

    // Decoded telegram, one-cycle valid
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            frm_valid_o <= 1'b0;
            frm_cmd_o   <= '0;
            frm_addr_o  <= '0;
            frm_data_o  <= '0;
            frm_ok_o    <= 1'b0;
        end else begin
            frm_valid_o <= take && !rx_sync_i && (end_hdr || end_long);
            frm_cmd_o   <= hdr[8:6];
            frm_addr_o  <= hdr[4:1];
            frm_data_o  <= nsh[14:1];
            frm_ok_o    <= hdr_ok && (!end_long || dat_ok);
        end
    end

    // Reply shifter, one bit per output bit time
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_sh_q  <= '0;
            tx_cnt_q <= '0;
            div_q    <= '0;
            tx_bit_o <= 1'b0;
            tx_stb_o <= 1'b0;
        end else if (tx_load_i) begin
            tx_sh_q  <= tx_word_i;
            tx_cnt_q <= tx_long_i ? 5'(REPLY_W) : 5'h1;
            div_q    <= '0;
            tx_stb_o <= 1'b0;
        end else begin
            tx_stb_o <= 1'b0;
            if (tx_cnt_q != 5'h0) begin
                div_q <= tick ? '0 : div_q + 32'h1;
                if (tick) begin
                    tx_bit_o <= tx_sh_q[15];
                    tx_stb_o <= 1'b1;
                    tx_sh_q  <= {tx_sh_q[14:0], 1'b0};
                    tx_cnt_q <= tx_cnt_q - 5'h1;
                end
            end
        end
    end

    assign tx_busy_o = tx_cnt_q != 5'h0;

endmodule : scr_frame

`default_nettype wire

// ==== sim/scr_prog_model.sv ====
// Programmer model: sends telegrams to the core, gathers reply bits.
// Assumes the core clock; drives its pins 1 ns after a rising edge.
`timescale 1ns/1ps
`default_nettype none

module scr_prog_model
    import scr_pkg::*;
(
    input  wire logic core_clk_i,
    input  wire logic out_bit_i,
    input  wire logic out_bit_stb_i,
    output logic      rx_sync_o,
    output logic      rx_bit_valid_o,
    output logic      rx_bit_o
);
    logic [15:0] rpl_q = 16'h0; // Reply bits, first one ends on top
    int          rpl_n = 0;     // Reply bits seen since the last send

    initial begin
        rx_sync_o = 1'b0;
        rx_bit_valid_o = 1'b0;
        rx_bit_o = 1'b0;
    end

    // Gather each reply bit on its strobe
    always @(posedge core_clk_i) begin
        if (out_bit_stb_i) begin
            rpl_q <= {rpl_q[14:0], out_bit_i};
            rpl_n <= rpl_n + 1;
        end
    end

    // One telegram; bad flips the command parity on purpose
    task automatic send(input logic [2:0] c, input logic [3:0] a,
                        input logic [13:0] d, input logic bad);
        logic [23:0] f;
        int          n;
        f = {c, ~^c ^ bad, a, ^a, d, ~^d};
        n = (c == CMD_WRITE) ? 24 : 9;
        rpl_n = 0;
        @(posedge core_clk_i) #1 rx_sync_o = 1'b1;
        @(posedge core_clk_i) #1 rx_sync_o = 1'b0;
        for (int i = 0; i < n; i++) begin
            rx_bit_valid_o = 1'b1;
            rx_bit_o = f[23-i];
            @(posedge core_clk_i) #1;
        end
        // Line left idle shows no stale bit
        rx_bit_valid_o = 1'b0;
        rx_bit_o = ~rx_bit_o;
    endtask : send
endmodule : scr_prog_model

`default_nettype wire

// ==== sim/tb.sv ====
// Self-checking bench of the register map core with a programmer model.
// Assumes a short reply bit time of 4 cycles.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, x) begin checks_done++; if ((g) !== (x)) begin mismatches++; \
 $display("Error t=%0t got %h exp %h", $time, g, x); end end

module tb
    import scr_pkg::*;
;
    logic        core_clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        reload_i = 1'b0;
    logic        act = 1'b0;     // Activate pin level
    logic        sync, vld, bit_i, ob, stb, low, lk;
    logic [7:0]  lclamp, cfg;
    logic [8:0]  hclamp;
    logic [9:0]  tcoef;
    logic [10:0] qlevel;
    logic [13:0] gain;
    logic [13:0] conv = 14'h0123; // Asymmetric, shows bit reversal
    logic [13:0] rv, e;
    logic [3:0]  a, w;
    logic [13:0] d;
    int          mismatches = 0;
    int          checks_done = 0;
    // Rows: address, valid width, data sent (upper junk must vanish)
    logic [21:0] rows[7] = '{{4'h1, 4'd8, 14'h3fa5}, {4'h2, 4'd9, 14'h01ab},
        {4'h3, 4'd11, 14'h05c3}, {4'h4, 4'd14, 14'h2bcd},
        {4'h5, 4'd8, 14'h007e}, {4'hb, 4'd10, 14'h02d5},
        {4'hc, 4'd13, 14'h1abc}};

    scr_regmap #(.BIT_CYCLES(4)) dut (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .reload_i(reload_i), .rx_sync_i(sync), .rx_bit_valid_i(vld),
        .rx_bit_i(bit_i), .activate_pin_i(act), .conv_value_i(conv),
        .out_bit_o(ob), .out_bit_stb_o(stb), .out_forced_low_o(low),
        .lock_active_o(lk), .low_clamp_o(lclamp), .high_clamp_o(hclamp),
        .quiescent_o(qlevel), .gain_o(gain), .config_o(cfg),
        .temp_coef_o(tcoef));
    scr_prog_model prog (.core_clk_i(core_clk_i), .out_bit_i(ob),
        .out_bit_stb_i(stb), .rx_sync_o(sync), .rx_bit_valid_o(vld),
        .rx_bit_o(bit_i));

    initial begin
        forever #12.5 core_clk_i = ~core_clk_i;
    end

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_sim

    // Send one telegram, expect n reply bits, then a quiet spell
    task automatic xfer(input logic [2:0] c, input logic [3:0] ad,
                        input logic [13:0] dd, input int n,
                        input logic bad = 1'b0);
        prog.send(c, ad, dd, bad);
        for (int k = 0; k < 400 && prog.rpl_n < n; k++) @(posedge core_clk_i);
        if (prog.rpl_n < n) begin
            mismatches++;
            end_sim();
        end
        repeat (40) @(posedge core_clk_i);
        `CHK(prog.rpl_n, n)
        $display("test cmd %h addr %h done", c, ad);
    endtask : xfer

    // Read and compare ack, high-aligned data and data parity
    task automatic rd(input logic [3:0] ad, input logic [13:0] v);
        xfer(CMD_READ, ad, 14'h0, 16);
        `CHK(prog.rpl_q, {1'b0, v, ~^v})
    endtask : rd

    // Ordinary supply cycle keeping the cells
    task automatic pwr;
        @(posedge core_clk_i) #1 reload_i = 1'b1;
        @(posedge core_clk_i) #1 reload_i = 1'b0;
        repeat (25) @(posedge core_clk_i);
    endtask : pwr

    initial begin
        repeat (10) @(posedge core_clk_i);
        #1 rst_i = 1'b0;
        repeat (25) @(posedge core_clk_i);
        `CHK(lclamp, 8'h00)
        foreach (rows[i]) begin
            {a, w, d} = rows[i];
            e = 14'((d & ((1 << w) - 1)) << (14 - w));
            xfer(CMD_WRITE, a, d, 1);
            xfer(CMD_ERASE, 4'h0, 14'h0, 1);
            xfer(CMD_PROG, 4'h0, 14'h0, 1);
            rd(a, e);
        end
        `CHK(lclamp, 8'ha5)
        `CHK(gain, 14'h2bcd)
        `CHK(hclamp, 9'h1ab)
        `CHK(qlevel, 11'h5c3)
        `CHK(cfg, 8'h7e)
        `CHK(tcoef, 10'h2d5)
        foreach (rv[i]) rv[i] = conv[13-i];
        rd(4'h9, rv);
        xfer(CMD_WRITE, 4'h9, 14'h0, 0);
        xfer(CMD_READ, 4'hf, 14'h0, 0);
        xfer(CMD_READ, 4'h1, 14'h0, 0, 1'b1);
        xfer(CMD_ERASE, 4'h1, 14'h0, 0);
        xfer(CMD_ERASE, 4'h0, 14'h0, 1);
        xfer(CMD_PROG, 4'h0, 14'h0, 1);
        pwr();
        rd(4'h1, 14'h2940);
        rd(4'hc, 14'h0);
        rd(4'h8, 14'h0);
        xfer(CMD_WRITE, 4'h5, 14'h007f, 1);
        `CHK(cfg, 8'h7f)
        xfer(CMD_WRITE, 4'hc, 14'h1abc, 1);
        xfer(CMD_WRITE, 4'h8, 14'h0000, 1);
        xfer(CMD_ERASE, 4'h0, 14'h0, 1);
        xfer(CMD_PROG, 4'h0, 14'h0, 1);
        pwr();
        rd(4'hc, 14'h3578);
        xfer(CMD_WRITE, 4'hf, 14'h080f, 0);
        `CHK(low, 1'b1)
        xfer(CMD_READ, 4'h1, 14'h0, 0);
        #1 act = 1'b1;
        repeat (8) @(posedge core_clk_i);
        `CHK(low, 1'b0)
        xfer(CMD_WRITE, 4'h6, 14'h0001, 1);
        `CHK(lk, 1'b0)
        pwr();
        `CHK(lk, 1'b1)
        xfer(CMD_WRITE, 4'h1, 14'h0, 0);
        rd(4'h1, 14'h2940);
        end_sim();
    end
endmodule : tb

`default_nettype wire
